/* hw/debug_port_pkg.sv */
// shared constants and carrier types of the two-wire debug register select
package debug_port_pkg;
    localparam int BYTE_W = 8;

    // register select codes
    localparam logic [7:0] SEL_PART_ID = 8'h00;
    localparam logic [7:0] SEL_REVISION = 8'h01;
    localparam logic [7:0] SEL_FLASH_CTRL = 8'h02;
    localparam logic [7:0] SEL_FLASH_DATA = 8'hb4;
    localparam logic [7:0] SEL_PART_ID_ALT = 8'hfd;
    localparam logic [7:0] SEL_REVISION_ALT = 8'hfe;

    // reset values and unmapped read filler
    localparam logic [7:0] SELECT_RESET = 8'h00;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] DATA_RESET = 8'h00;
    localparam logic [7:0] UNMAPPED_READ = 8'h00;

    // flash enable key, in order
    localparam logic [7:0] UNLOCK_FIRST = 8'h02;
    localparam logic [7:0] UNLOCK_SECOND = 8'h01;

    // flash command codes
    localparam logic [7:0] CMD_BLOCK_READ = 8'h06;
    localparam logic [7:0] CMD_BLOCK_WRITE = 8'h07;
    localparam logic [7:0] CMD_PAGE_ERASE = 8'h08;
    localparam logic [7:0] CMD_DEVICE_ERASE = 8'h03;

    // link framing: start bit, two instruction bits lsb first, one byte
    localparam logic START_LEVEL = 1'b0;
    localparam logic IDLE_LEVEL = 1'b1;
    localparam logic [1:0] INSTR_DATA_READ = 2'h0;
    localparam logic [1:0] INSTR_DATA_WRITE = 2'h1;
    localparam logic [1:0] INSTR_ADDR_READ = 2'h2;
    localparam logic [1:0] INSTR_ADDR_WRITE = 2'h3;
    localparam logic [2:0] CNT_RESET = 3'h0;
    localparam logic [2:0] CNT_STEP = 3'h1;
    localparam logic [2:0] INSTR_LAST_BIT = 3'h1;
    localparam logic [2:0] BYTE_LAST_BIT = 3'h7;

    typedef struct packed {
        logic rise;
        logic fall;
        logic data;
    } link_sample_t;

    typedef struct packed {
        logic valid;
        logic is_command;
        logic [7:0] data;
    } flash_req_t;
endpackage

/* hw/link_sampler.sv */
// synchronises link clock and data pins and finds link clock edges
`timescale 1ns/100ps
module link_sampler (
    // clock and reset
    input wire logic clock_in,
    input wire logic rst_n_in,
    // pins
    input wire logic link_clock_in,
    input wire logic link_data_in,
    // sampled view
    output debug_port_pkg::link_sample_t sample_out
);
    logic clk_meta_q;
    logic clk_sync_q;
    logic clk_prev_q;
    logic data_meta_q;
    logic data_sync_q;

    // idle levels at reset so no false edge appears on release
    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            clk_meta_q <= 1'b0;
            clk_sync_q <= 1'b0;
            clk_prev_q <= 1'b0;
            data_meta_q <= debug_port_pkg::IDLE_LEVEL;
            data_sync_q <= debug_port_pkg::IDLE_LEVEL;
        end else begin
            clk_meta_q <= link_clock_in;
            clk_sync_q <= clk_meta_q;
            clk_prev_q <= clk_sync_q;
            data_meta_q <= link_data_in;
            data_sync_q <= data_meta_q;
        end
    end

    assign sample_out.rise = clk_sync_q & ~clk_prev_q;
    assign sample_out.fall = ~clk_sync_q & clk_prev_q;
    assign sample_out.data = data_sync_q;
endmodule // link_sampler

/* hw/flash_unlock.sv */
// key sequence that enables flash programming until reset
`timescale 1ns/100ps
module flash_unlock (
    // clock and reset
    input wire logic clock_in,
    input wire logic rst_n_in,
    // control register writes
    input wire logic ctrl_write_in,
    input wire logic [7:0] ctrl_byte_in,
    // result
    output logic enable_out
);
    typedef enum logic [1:0] {LOCKED, ARMED, ENABLED} unlock_state_t;
    unlock_state_t state_q;
    unlock_state_t state_d;

    wire key_first = ctrl_write_in
        && ctrl_byte_in == debug_port_pkg::UNLOCK_FIRST;
    wire key_second = ctrl_write_in
        && ctrl_byte_in == debug_port_pkg::UNLOCK_SECOND;

    always_comb begin
        state_d = state_q;
        case (state_q)
            LOCKED: if (key_first) state_d = ARMED; // [R10]
            ARMED: begin
                if (key_second) begin
                    state_d = ENABLED; // [R10]
                end else if (ctrl_write_in && !key_first) begin
                    state_d = LOCKED;
                end
            end
            // only a reset leaves this state
            ENABLED: state_d = ENABLED; // [R11]
            default: state_d = LOCKED;
        endcase
    end

    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            state_q <= LOCKED;
            enable_out <= 1'b0;
        end else begin
            state_q <= state_d;
            enable_out <= state_d == ENABLED;
        end
    end

    property p_unlock_order;
        @(posedge clock_in) disable iff (!rst_n_in)
        state_q == ARMED && key_second |=> enable_out;
    endproperty
    a_unlock_order: assert property (p_unlock_order) // [R10]
        else $error("second key after first did not enable");

    property p_no_skip;
        @(posedge clock_in) disable iff (!rst_n_in)
        state_q == LOCKED && !enable_out |=> !enable_out;
    endproperty
    a_no_skip: assert property (p_no_skip) // [R10]
        else $error("enable without first key");

    property p_sticky;
        @(posedge clock_in) disable iff (!rst_n_in)
        enable_out |=> enable_out;
    endproperty
    a_sticky: assert property (p_sticky) // [R11]
        else $error("flash enable dropped without reset");

    c_enabled: cover property (@(posedge clock_in) $rose(enable_out));
endmodule // flash_unlock

/* hw/two_wire_debug_register_select.sv */
// register select front end of the two-wire debug and programming port
// Function
// R1 - all traffic uses one host clock line and one shared data line
// R2 - port registers reachable only through the two-wire link
// R3 - 8-bit select register chooses target of data reads and writes
// R4 - select 0x00 reads return the part identifier
// R5 - select 0x01 reads return the silicon revision
// R6 - select 0x02 reads and writes reach flash program control
// R7 - select 0xb4 reads and writes reach flash program data
// R8 - part identifier is read-only fixed 8-bit family code
// R9 - silicon revision is read-only 8-bit revision code
// R10 - host enables flashing by writing control 0x02 then 0x01
// R11 - flash enable holds until system reset
// R12 - data register carries commands 0x06 0x07 0x08 0x03, addresses, data
// R13 - data writes to identifier or revision are ignored
// R14 - select register resets to zero, picking the identifier
`timescale 1ns/100ps
module two_wire_debug_register_select #(
    // arbitrary family code
    parameter logic [7:0] PART_ID = 8'h3c,
    // arbitrary revision code
    parameter logic [7:0] REVISION = 8'h5a
) (
    // clock and reset
    input wire logic clock_in,
    input wire logic rst_n_in,
    // two-wire link
    input wire logic debug_link_clock_in,
    input wire logic debug_link_data_in,
    output logic debug_link_data_out,
    output logic debug_link_data_oe_n_out,
    // flash engine side
    input wire logic [7:0] flash_read_data_in,
    input wire logic flash_read_valid_in,
    output debug_port_pkg::flash_req_t flash_request_out,
    output logic flash_program_enable_out,
    // status
    output logic [7:0] debug_register_select_out
);
    typedef enum logic [1:0] {IDLE, INSTR, WDATA, RDATA} link_state_t;

    debug_port_pkg::link_sample_t smp;
    link_state_t state_q;
    link_state_t state_d;
    logic [1:0] instr_q;
    logic [2:0] cnt_q;
    logic [7:0] shift_q;
    logic [7:0] select_q;
    logic [7:0] ctrl_q;
    logic [7:0] flash_data_q;
    logic drive_q;
    logic oe_n_q;
    debug_port_pkg::flash_req_t req_q;
    logic enable;

    // both pins pass two flops before use
    link_sampler u_sampler (
        .clock_in(clock_in),
        .rst_n_in(rst_n_in),
        .link_clock_in(debug_link_clock_in),
        .link_data_in(debug_link_data_in),
        .sample_out(smp)
    );

    // framing decode
    wire cnt_instr_last = cnt_q == debug_port_pkg::INSTR_LAST_BIT;
    wire cnt_byte_last = cnt_q == debug_port_pkg::BYTE_LAST_BIT;
    wire [1:0] instr_full = {smp.data, instr_q[1]};
    wire [7:0] wbyte = {smp.data, shift_q[7:1]};
    wire start_seen = state_q == IDLE && smp.rise
        && smp.data == debug_port_pkg::START_LEVEL;
    wire instr_done = state_q == INSTR && smp.rise && cnt_instr_last;
    wire is_read = instr_full == debug_port_pkg::INSTR_DATA_READ
        || instr_full == debug_port_pkg::INSTR_ADDR_READ;
    wire load_read = instr_done && is_read;
    wire commit = state_q == WDATA && smp.rise && cnt_byte_last;
    wire commit_addr = commit
        && instr_q == debug_port_pkg::INSTR_ADDR_WRITE;
    wire commit_data = commit
        && instr_q == debug_port_pkg::INSTR_DATA_WRITE;
    wire read_done = state_q == RDATA && smp.rise && cnt_byte_last;

    // target decode from the select register
    wire sel_id = select_q == debug_port_pkg::SEL_PART_ID
        || select_q == debug_port_pkg::SEL_PART_ID_ALT; // [R4]
    wire sel_rev = select_q == debug_port_pkg::SEL_REVISION
        || select_q == debug_port_pkg::SEL_REVISION_ALT; // [R5]
    wire sel_ctrl = select_q == debug_port_pkg::SEL_FLASH_CTRL; // [R6]
    wire sel_data = select_q == debug_port_pkg::SEL_FLASH_DATA; // [R7]

    // identifier and revision are constants, so no write path exists
    wire [7:0] read_value =
        instr_full == debug_port_pkg::INSTR_ADDR_READ ? select_q :
        sel_id ? PART_ID : // [R8]
        sel_rev ? REVISION : // [R9]
        sel_ctrl ? ctrl_q :
        sel_data ? flash_data_q :
        debug_port_pkg::UNMAPPED_READ; // [R3]

    // writes to identifier, revision or unmapped targets fall through
    wire ctrl_write = commit_data && sel_ctrl; // [R6] [R13]
    wire data_write = commit_data && sel_data; // [R7] [R13]
    wire is_command = wbyte == debug_port_pkg::CMD_BLOCK_READ
        || wbyte == debug_port_pkg::CMD_BLOCK_WRITE
        || wbyte == debug_port_pkg::CMD_PAGE_ERASE
        || wbyte == debug_port_pkg::CMD_DEVICE_ERASE; // [R12]

    // host write beats an engine load in the same cycle
    wire [7:0] flash_data_d = data_write ? wbyte :
        flash_read_valid_in ? flash_read_data_in : flash_data_q; // [R7]
    wire [7:0] select_d = commit_addr ? wbyte : select_q; // [R3]
    wire [7:0] ctrl_d = ctrl_write ? wbyte : ctrl_q; // [R6]

    flash_unlock u_unlock (
        .clock_in(clock_in),
        .rst_n_in(rst_n_in),
        .ctrl_write_in(ctrl_write),
        .ctrl_byte_in(wbyte),
        .enable_out(enable)
    );

    // link frame sequence
    always_comb begin
        state_d = state_q;
        case (state_q)
            IDLE: if (start_seen) state_d = INSTR;
            INSTR: if (instr_done) state_d = is_read ? RDATA : WDATA;
            WDATA: if (commit) state_d = IDLE;
            RDATA: if (read_done) state_d = IDLE;
            default: state_d = IDLE;
        endcase
    end

    wire [2:0] cnt_d = state_d != state_q ? debug_port_pkg::CNT_RESET :
        smp.rise ? cnt_q + debug_port_pkg::CNT_STEP : cnt_q;

    wire [7:0] shift_d = load_read ? read_value :
        state_q == WDATA && smp.rise ? wbyte :
        state_q == RDATA && smp.rise ? {1'b0, shift_q[7:1]} : shift_q;

    wire [1:0] instr_d = state_q == INSTR && smp.rise ?
        instr_full : instr_q;

    // drive on link clock fall so the host samples a settled bit
    wire drive_d = state_q == RDATA && smp.fall ? shift_q[0] : drive_q;
    wire oe_n_d = read_done ? 1'b1 :
        state_q == RDATA && smp.fall ? 1'b0 : oe_n_q; // [R1]

    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            state_q <= IDLE;
            instr_q <= debug_port_pkg::INSTR_DATA_READ;
            cnt_q <= debug_port_pkg::CNT_RESET;
            shift_q <= debug_port_pkg::DATA_RESET;
            drive_q <= debug_port_pkg::IDLE_LEVEL;
            oe_n_q <= 1'b1;
        end else begin
            state_q <= state_d;
            instr_q <= instr_d;
            cnt_q <= cnt_d;
            shift_q <= shift_d;
            drive_q <= drive_d;
            oe_n_q <= oe_n_d;
        end
    end

    // registers written from the link, flash data also from the flash engine, never a cpu bus
    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            select_q <= debug_port_pkg::SELECT_RESET; // [R14] [R2]
            ctrl_q <= debug_port_pkg::CTRL_RESET;
            flash_data_q <= debug_port_pkg::DATA_RESET;
            req_q <= '0;
        end else begin
            select_q <= select_d;
            ctrl_q <= ctrl_d;
            flash_data_q <= flash_data_d;
            req_q.valid <= data_write && enable; // [R12]
            req_q.is_command <= is_command;
            req_q.data <= wbyte;
        end
    end

    assign debug_link_data_out = drive_q;
    assign debug_link_data_oe_n_out = oe_n_q;
    assign flash_request_out = req_q;
    assign flash_program_enable_out = enable;
    assign debug_register_select_out = select_q;

    default clocking cb @(posedge clock_in);
    endclocking
    default disable iff (!rst_n_in);

    property p_select_reset;
        $rose(rst_n_in) |-> select_q == debug_port_pkg::SELECT_RESET;
    endproperty
    a_select_reset: assert property (p_select_reset) // [R14]
        else $error("select register not zero after reset");

    property p_addr_write;
        commit_addr |=> select_q == $past(wbyte)
            && state_q == IDLE;
    endproperty
    a_addr_write: assert property (p_addr_write) // [R3]
        else $error("address write did not load select");

    property p_read_id;
        load_read && sel_id
            && instr_full == debug_port_pkg::INSTR_DATA_READ
            |=> shift_q == PART_ID && state_q == RDATA;
    endproperty
    a_read_id: assert property (p_read_id) // [R4] [R8]
        else $error("identifier read returned wrong value");

    property p_read_rev;
        load_read && sel_rev
            && instr_full == debug_port_pkg::INSTR_DATA_READ
            |=> shift_q == REVISION;
    endproperty
    a_read_rev: assert property (p_read_rev) // [R5] [R9]
        else $error("revision read returned wrong value");

    property p_ctrl_write;
        commit_data && sel_ctrl |=> ctrl_q == $past(wbyte);
    endproperty
    a_ctrl_write: assert property (p_ctrl_write) // [R6]
        else $error("control write lost");

    property p_data_write;
        commit_data && sel_data
            |=> flash_data_q == $past(wbyte)
            && req_q.valid == enable && req_q.data == flash_data_q;
    endproperty
    a_data_write: assert property (p_data_write) // [R7] [R12]
        else $error("data write lost or request wrong");

    property p_ignored_write;
        commit_data && (sel_id || sel_rev)
            |=> $stable(ctrl_q) && !req_q.valid
            && ($stable(flash_data_q) || $past(flash_read_valid_in))
            && !enable == !$past(enable);
    endproperty
    a_ignored_write: assert property (p_ignored_write) // [R13]
        else $error("write to read-only target had effect");

    property p_drive_window;
        !oe_n_q |-> state_q == RDATA || $past(read_done);
    endproperty
    a_drive_window: assert property (p_drive_window) // [R1]
        else $error("data line driven outside a read");

    property p_release;
        read_done |=> oe_n_q ##1 oe_n_q;
    endproperty
    a_release: assert property (p_release) // [R1]
        else $error("data line not released after read");

    property p_addr_read;
        load_read && instr_full == debug_port_pkg::INSTR_ADDR_READ
            |=> shift_q == $past(select_q);
    endproperty
    a_addr_read: assert property (p_addr_read) // [R3]
        else $error("address read did not load select");

    property p_read_ctrl;
        load_read && sel_ctrl
            && instr_full == debug_port_pkg::INSTR_DATA_READ
            |=> shift_q == $past(ctrl_q);
    endproperty
    a_read_ctrl: assert property (p_read_ctrl) // [R6]
        else $error("control read returned wrong value");

    property p_read_data;
        load_read && sel_data
            && instr_full == debug_port_pkg::INSTR_DATA_READ
            |=> shift_q == $past(flash_data_q);
    endproperty
    a_read_data: assert property (p_read_data) // [R7]
        else $error("flash data read returned wrong value");

    // unmapped selects read a fixed filler value
    property p_read_unmapped;
        load_read && !(sel_id || sel_rev || sel_ctrl || sel_data)
            && instr_full == debug_port_pkg::INSTR_DATA_READ
            |=> shift_q == debug_port_pkg::UNMAPPED_READ;
    endproperty
    a_read_unmapped: assert property (p_read_unmapped) // [R3]
        else $error("unmapped read returned wrong value");

    property p_engine_load;
        flash_read_valid_in && !data_write
            |=> flash_data_q == $past(flash_read_data_in);
    endproperty
    a_engine_load: assert property (p_engine_load) // [R7]
        else $error("engine byte not loaded into flash data");

    property p_locked_quiet;
        !enable |=> !req_q.valid;
    endproperty
    a_locked_quiet: assert property (p_locked_quiet) // [R12]
        else $error("flash request while programming disabled");

    property p_drive_bit;
        state_q == RDATA && smp.fall
            |=> !oe_n_q && debug_link_data_out == $past(shift_q[0]);
    endproperty
    a_drive_bit: assert property (p_drive_bit) // [R1]
        else $error("read bit not driven at link clock fall");

    c_read_id: cover property (load_read && sel_id);
    c_addr_write: cover property (commit_addr);
    c_flash_req: cover property (req_q.valid && req_q.is_command);
endmodule // two_wire_debug_register_select

/* tb/debug_host_model.sv */
// host side model of the two-wire debug link
`timescale 1ns/100ps
module debug_host_model (
    // device side of the shared wire
    input wire logic dev_data_in,
    input wire logic dev_oe_n_in,
    // link pins as the device sees them
    output logic link_clock_out,
    output logic link_wire_out
);
    logic host_drive;
    logic host_val;

    // device wins when enabled, else host, else pull-up
    assign link_wire_out = !dev_oe_n_in ? dev_data_in :
        (host_drive ? host_val : 1'b1);

    initial begin
        link_clock_out = 1'b0;
        host_drive = 1'b0;
        host_val = 1'b1;
    end

    task automatic send_bit(input logic b);
        host_val = b;
        host_drive = 1'b1;
        #40 link_clock_out = 1'b1;
        #40 link_clock_out = 1'b0;
    endtask

    // one frame, clock low between frames
    task automatic frame(input logic [1:0] code, input logic [7:0] wr,
                         output logic [7:0] rd);
        rd = 8'h00;
        // odd offset keeps link edges off the system clock phase
        #1.3;
        send_bit(debug_port_pkg::START_LEVEL);
        send_bit(code[0]);
        send_bit(code[1]);
        if (code[0]) begin
            for (int i = 0; i < 8; i++) send_bit(wr[i]);
            host_drive = 1'b0;
        end else begin
            // let go at the fall so the device can take the wire
            host_drive = 1'b0;
            for (int i = 0; i < 8; i++) begin
                #40 link_clock_out = 1'b1;
                rd[i] = link_wire_out;
                #40 link_clock_out = 1'b0;
            end
        end
        #80;
    endtask
endmodule // debug_host_model

/* tb/two_wire_debug_register_select_bench.sv */
// self-checking bench of the two-wire debug register select
`timescale 1ns/100ps
module two_wire_debug_register_select_bench;
    localparam logic [7:0] PART_ID = 8'h3c; // arbitrary value
    localparam logic [7:0] REVISION = 8'h5a; // arbitrary value
    localparam logic [1:0] DR = debug_port_pkg::INSTR_DATA_READ;
    localparam logic [1:0] DW = debug_port_pkg::INSTR_DATA_WRITE;
    localparam logic [1:0] AR = debug_port_pkg::INSTR_ADDR_READ;
    localparam logic [1:0] AW = debug_port_pkg::INSTR_ADDR_WRITE;
    logic clock_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic link_clock;
    logic link_wire;
    logic dev_data;
    logic dev_oe_n;
    logic [7:0] fl_rd = 8'h00;
    logic fl_valid = 1'b0;
    debug_port_pkg::flash_req_t req;
    logic enable;
    logic [7:0] select;
    int failures = 0;
    int checks = 0;
    integer seed = 32'hf2fedf6f;
    logic [7:0] m_sel, m_ctrl, m_data, rd, b;
    int m_en, m_armed;
    logic [8:0] req_q[$];
    logic [8:0] exp_q[$];
    logic [7:0] tab[7] = '{8'h00, 8'h01, 8'h02, 8'hb4, 8'hfd, 8'hfe, 8'h5c};
    logic [7:0] cmds[5] = '{8'h06, 8'h07, 8'h08, 8'h03, 8'h41};

    always #2 clock_in = ~clock_in;

    two_wire_debug_register_select #(
        .PART_ID(PART_ID),
        .REVISION(REVISION)
    ) i_two_wire_debug_register_select (
        .clock_in(clock_in), .rst_n_in(rst_n_in),
        .debug_link_clock_in(link_clock), .debug_link_data_in(link_wire),
        .debug_link_data_out(dev_data), .debug_link_data_oe_n_out(dev_oe_n),
        .flash_read_data_in(fl_rd), .flash_read_valid_in(fl_valid),
        .flash_request_out(req), .flash_program_enable_out(enable),
        .debug_register_select_out(select));

    debug_host_model i_debug_host_model (
        .dev_data_in(dev_data), .dev_oe_n_in(dev_oe_n),
        .link_clock_out(link_clock), .link_wire_out(link_wire));

    always @(posedge clock_in)
        if (req.valid === 1'b1) req_q.push_back({req.is_command, req.data});

    task automatic check(input logic [8:0] seen, input logic [8:0] exp);
        checks++;
        if (seen !== exp) begin
            failures++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic final_report();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    function automatic logic [7:0] exp_read();
        case (m_sel)
            8'h00, 8'hfd: return PART_ID;
            8'h01, 8'hfe: return REVISION;
            8'h02: return m_ctrl;
            8'hb4: return m_data;
            default: return 8'h00;
        endcase
    endfunction

    task automatic do_reset();
        @(posedge clock_in) rst_n_in <= 1'b0;
        repeat (10) @(posedge clock_in);
        rst_n_in <= 1'b1;
        {m_sel, m_ctrl, m_data, m_en, m_armed} = '0;
        repeat (3) @(posedge clock_in);
        #1;
        check(select, 8'h00);
        check(enable, 1'b0);
        check({dev_oe_n, dev_data, req.valid}, 3'b110);
    endtask

    task automatic do_write(input logic [1:0] code, input logic [7:0] v);
        i_debug_host_model.frame(code, v, rd);
        if (code == AW) m_sel = v;
        else if (m_sel == 8'h02) begin
            m_ctrl = v;
            if (m_en == 0) begin
                if (v == 8'h02) m_armed = 1;
                else if (v == 8'h01 && m_armed == 1) m_en = 1;
                else m_armed = 0;
            end
        end else if (m_sel == 8'hb4) begin
            m_data = v;
            if (m_en == 1)
                exp_q.push_back({v inside {8'h06, 8'h07, 8'h08, 8'h03}, v});
        end
        repeat (2) @(posedge clock_in);
        #1;
        check(select, m_sel);
        check(enable, m_en[0]);
        check(9'(req_q.size()), 9'(exp_q.size()));
        while (exp_q.size() > 0 && req_q.size() > 0)
            check(req_q.pop_front(), exp_q.pop_front());
        req_q.delete();
        exp_q.delete();
    endtask

    task automatic do_read(input logic [1:0] code);
        i_debug_host_model.frame(code, 8'h00, rd);
        check(rd, code == AR ? m_sel : exp_read());
    endtask

    initial begin
        #300000;
        failures++;
        final_report();
    end

    initial begin
        do_reset();
        do_read(DR);
        $display("test reset done");
        // random unmapped select, kept off the mapped codes
        b = 8'($random(seed));
        tab[6] = (b inside {8'h00, 8'h01, 8'h02, 8'hb4, 8'hfd, 8'hfe}) ?
            8'h5c : b;
        foreach (tab[i]) begin
            do_write(AW, tab[i]);
            do_read(AR);
            // bit 4 set keeps the enable key out of reach here
            do_write(DW, 8'($random(seed)) | 8'h10);
            do_read(DR);
        end
        $display("test select done");
        do_write(AW, 8'h02);
        do_write(DW, 8'h02);
        do_write(DW, 8'h07);
        do_write(DW, 8'h02);
        do_write(DW, 8'h02);
        do_write(DW, 8'h01);
        do_read(DR);
        $display("test unlock done");
        do_write(AW, 8'hb4);
        foreach (cmds[i]) do_write(DW, cmds[i]);
        b = 8'($random(seed));
        @(posedge clock_in);
        fl_rd <= b;
        fl_valid <= 1'b1;
        @(posedge clock_in);
        fl_valid <= 1'b0;
        m_data = b;
        do_read(DR);
        $display("test flash done");
        do_write(AW, 8'h02);
        do_write(DW, 8'h00);
        do_reset();
        do_read(DR);
        $display("test sticky done");
        final_report();
    end
endmodule // two_wire_debug_register_select_bench
